// ===== core/error_log_capture_registers.sv
// Sticky first-error log bank with APB access, status and interrupt.
// How it works
// - The fatal port protocol log takes the 64-bit header of the first fatal protocol error.
// - A log is loaded only together with its first-error status bit, which qualifies it.
// - Errors without a log set their own status bit and leave every log untouched.
// - The data log keeps 64 data bits and 8 parity bits above them for the first data error.
// - The data bits logged are the half of the 128-bit bus that carried the error.
// - Data logs are loaded within ten clocks and then held until their status bit clears.
// - Each port ECC log keeps the syndrome in bits 15:8 and the received ECC in bits 7:0.
// - The syndrome is stored as computed, so it keeps the error type and failing bit.
// - Each port physical log takes the 64-bit header or physical_unit detail of its first error.
// - The memory log keeps channel, DIMM, bank, row and column; bits 63:40 read zero.
// - The logged column always shows the auto-precharge bit set.
`timescale 1ns/10ps
`default_nettype none
`include "errlog_params.svh"

module error_log_capture_registers (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  por,
    input  wire errlog_pkg::apb_req_s  apb_req,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata,
    input  wire errlog_pkg::hdr_event_s fatal_pp_event,
    input  wire errlog_pkg::data_event_s data_event,
    input  wire errlog_pkg::ecc_event_s ecc_event_0,
    input  wire errlog_pkg::ecc_event_s ecc_event_1,
    input  wire errlog_pkg::hdr_event_s phys_event_0,
    input  wire errlog_pkg::hdr_event_s phys_event_1,
    input  wire errlog_pkg::mem_event_s mem_event,
    input  wire logic                  unlogged_event,
    output logic                       err_irq
);
    import errlog_pkg::*;

    // ========================================================================
    // Status and interrupt
    // ========================================================================
    logic [`FES_W-1:0] first_error_status_q;
    logic [`FES_W-1:0] first_error_status_d;
    logic [`FES_W-1:0] fes_set;
    logic [`FES_W-1:0] fes_clr;
    logic [`FES_W-1:0] fes_free;
    logic [`FES_W-1:0] irq_enable_q;
    logic              bus_write;
    logic              bus_setup;
    logic              bus_access;

    assign bus_setup  = apb_req.psel && !apb_req.penable;
    assign bus_access = apb_req.psel && apb_req.penable;
    assign bus_write  = bus_access && apb_req.pwrite;

    always_comb
    begin
        fes_set                = '0;
        fes_set[`FES_FATAL_PP] = fatal_pp_event.valid;
        fes_set[`FES_DATA]     = data_event.valid;
        fes_set[`FES_ECC0]     = ecc_event_0.valid;
        fes_set[`FES_ECC1]     = ecc_event_1.valid;
        fes_set[`FES_PHYS0]    = phys_event_0.valid;
        fes_set[`FES_PHYS1]    = phys_event_1.valid;
        fes_set[`FES_MEM]      = mem_event.valid;
        fes_set[`FES_UNLOGGED] = unlogged_event;
    end

    assign fes_clr = (bus_write && apb_req.paddr == `OFF_FIRST_ERR) ?
                     apb_req.pwdata[`FES_W-1:0] : '0;
    // A slot may load when it holds nothing or is being released this cycle.
    assign fes_free = ~first_error_status_q | fes_clr;
    // A new error in the clearing cycle keeps its status bit set.
    assign first_error_status_d = (first_error_status_q & ~fes_clr) | fes_set;

    always_ff @(posedge sys_clk)
    begin
        if (por)
            first_error_status_q <= `FES_RESET;
        else
            first_error_status_q <= first_error_status_d;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst || por)
            irq_enable_q <= `IRQ_EN_RESET;
        else if (bus_write && apb_req.paddr == `OFF_IRQ_ENABLE)
            irq_enable_q <= apb_req.pwdata[`FES_W-1:0];
    end

    assign err_irq = |(first_error_status_q & irq_enable_q);

    // ========================================================================
    // Log capture
    // ========================================================================
    logic [63:0] fatal_pp_log_q;
    logic [63:0] data_log_q;
    logic [7:0]  data_par_q;
    logic [15:0] ecc_log_q  [2];
    logic [63:0] phys_log_q [2];
    logic [39:0] mem_log_q;
    ecc_event_s  ecc_ev     [2];
    hdr_event_s  phys_ev    [2];

    assign ecc_ev[0]  = ecc_event_0;
    assign ecc_ev[1]  = ecc_event_1;
    assign phys_ev[0] = phys_event_0;
    assign phys_ev[1] = phys_event_1;

    always_ff @(posedge sys_clk)
    begin
        if (por)
            fatal_pp_log_q <= '0;
        else if (fatal_pp_event.valid && fes_free[`FES_FATAL_PP])
            fatal_pp_log_q <= fatal_pp_event.header;
    end

    always_ff @(posedge sys_clk)
    begin
        if (por)
        begin
            data_log_q <= '0;
            data_par_q <= '0;
        end
        else if (data_event.valid && fes_free[`FES_DATA])
        begin
            data_log_q <= data_event.upper_half ? data_event.bus_data[127:64]
                                                : data_event.bus_data[63:0];
            data_par_q <= data_event.data_parity_bits;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (por)
            begin
                ecc_log_q[p]  <= '0;
                phys_log_q[p] <= '0;
            end
            else
            begin
                if (ecc_ev[p].valid && fes_free[`FES_ECC0 + p])
                    ecc_log_q[p] <= {ecc_ev[p].syndrome, ecc_ev[p].ecc};
                if (phys_ev[p].valid && fes_free[`FES_PHYS0 + p])
                    phys_log_q[p] <= phys_ev[p].header;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (por)
            mem_log_q <= '0;
        else if (mem_event.valid && fes_free[`FES_MEM])
            mem_log_q <= {mem_event.channel, mem_event.dimm, mem_event.bank,
                          mem_event.row, mem_event.column[12:`COL_AP_BIT+1], 1'b1,
                          mem_event.column[`COL_AP_BIT-1:0]};
    end

    // ========================================================================
    // APB read path
    // ========================================================================
    logic [31:0] rd_data;
    logic        rd_hit;
    logic [31:0] prdata_q;

    always_comb
    begin
        rd_data = '0;
        rd_hit  = 1'b1;
        unique case (apb_req.paddr)
            `OFF_FATAL_PP_LO: rd_data = fatal_pp_log_q[31:0];
            `OFF_FATAL_PP_HI: rd_data = fatal_pp_log_q[63:32];
            `OFF_DATA_LO:     rd_data = data_log_q[31:0];
            `OFF_DATA_HI:     rd_data = data_log_q[63:32];
            `OFF_DATA_PAR:    rd_data = {24'h000000, data_par_q};
            `OFF_ECC_PORT0:   rd_data = {16'h0000, ecc_log_q[0]};
            `OFF_ECC_PORT1:   rd_data = {16'h0000, ecc_log_q[1]};
            `OFF_PHYS0_LO:    rd_data = phys_log_q[0][31:0];
            `OFF_PHYS0_HI:    rd_data = phys_log_q[0][63:32];
            `OFF_PHYS1_LO:    rd_data = phys_log_q[1][31:0];
            `OFF_PHYS1_HI:    rd_data = phys_log_q[1][63:32];
            `OFF_MEM_LO:      rd_data = mem_log_q[31:0];
            `OFF_MEM_HI:      rd_data = {{`MEM_RSVD_W{1'b0}}, mem_log_q[39:32]};
            `OFF_FIRST_ERR:   rd_data = {24'h000000, first_error_status_q};
            `OFF_IRQ_ENABLE:  rd_data = {24'h000000, irq_enable_q};
            default:          rd_hit  = 1'b0;
        endcase
    end

    // Read data is taken in the setup cycle so the access phase needs no wait.
    always_ff @(posedge sys_clk)
    begin
        if (rst || por)
            prdata_q <= '0;
        else if (bus_setup)
            prdata_q <= rd_data;
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = bus_access && !rd_hit;

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || por);

    sequence s_data_taken;
        data_event.valid && fes_free[`FES_DATA];
    endsequence

    sequence s_data_held;
        first_error_status_q[`FES_DATA] && !fes_clr[`FES_DATA];
    endsequence

    property p_fatal_capture;
        fatal_pp_event.valid && fes_free[`FES_FATAL_PP]
            |=> fatal_pp_log_q == $past(fatal_pp_event.header);
    endproperty
    a_fatal_capture: assert property (p_fatal_capture)
        else $error("fatal protocol log did not take the header");

    property p_log_qualified;
        !$stable(phys_log_q[0]) |-> first_error_status_q[`FES_PHYS0];
    endproperty
    a_log_qualified: assert property (p_log_qualified)
        else $error("physical log changed without its status bit");

    property p_unlogged;
        unlogged_event |=> first_error_status_q[`FES_UNLOGGED] && $stable(fatal_pp_log_q);
    endproperty
    a_unlogged: assert property (p_unlogged)
        else $error("unlogged error not shown or touched a log");

    property p_data_parity;
        s_data_taken |=> data_par_q == $past(data_event.data_parity_bits);
    endproperty
    a_data_parity: assert property (p_data_parity)
        else $error("data parity bits not logged");

    property p_data_half;
        s_data_taken ##0 data_event.upper_half
            |=> data_log_q == $past(data_event.bus_data[127:64]);
    endproperty
    a_data_half: assert property (p_data_half)
        else $error("upper data half not logged");

    property p_data_hold;
        s_data_held |=> $stable(data_log_q) && $stable(data_par_q);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data log changed while held");

    property p_data_defined;
        s_data_taken |-> ##[1:`LOG_DEFINED_CLKS] first_error_status_q[`FES_DATA];
    endproperty
    a_data_defined: assert property (p_data_defined)
        else $error("data log not marked within ten clocks");

    property p_ecc_fields;
        ecc_event_1.valid && fes_free[`FES_ECC1]
            |=> ecc_log_q[1][15:8] == $past(ecc_event_1.syndrome)
                && ecc_log_q[1][7:0] == $past(ecc_event_1.ecc);
    endproperty
    a_ecc_fields: assert property (p_ecc_fields)
        else $error("port ECC log fields wrong");

    property p_phys_first;
        first_error_status_q[`FES_PHYS1] && !fes_clr[`FES_PHYS1] |=> $stable(phys_log_q[1]);
    endproperty
    a_phys_first: assert property (p_phys_first)
        else $error("physical log overwritten by later error");

    property p_mem_fields;
        mem_event.valid && fes_free[`FES_MEM]
            |=> mem_log_q[`MEM_CHAN_BIT] == $past(mem_event.channel)
                && mem_log_q[`MEM_BANK_LSB+5:`MEM_BANK_LSB] == $past(mem_event.bank)
                && mem_log_q[`MEM_ROW_LSB+14:`MEM_ROW_LSB] == $past(mem_event.row);
    endproperty
    a_mem_fields: assert property (p_mem_fields)
        else $error("memory log fields wrong");

    property p_mem_ap_bit;
        first_error_status_q[`FES_MEM] && $past(first_error_status_q[`FES_MEM])
            |-> mem_log_q[`COL_AP_BIT];
    endproperty
    a_mem_ap_bit: assert property (p_mem_ap_bit)
        else $error("auto-precharge column bit not set");

    property p_read_only;
        bus_write && apb_req.paddr == `OFF_FATAL_PP_LO && !fatal_pp_event.valid
            |=> $stable(fatal_pp_log_q);
    endproperty
    a_read_only: assert property (p_read_only)
        else $error("software write changed a log");

endmodule
`default_nettype wire

// ===== core/errlog_params.svh
// Offsets, field positions, reset values and counts of the error log bank.
`ifndef ERRLOG_PARAMS_SVH
`define ERRLOG_PARAMS_SVH

`define ADDR_W              12
`define OFF_FATAL_PP_LO     12'h048
`define OFF_FATAL_PP_HI     12'h04C
`define OFF_DATA_LO         12'h050
`define OFF_DATA_HI         12'h054
`define OFF_DATA_PAR        12'h058
`define OFF_ECC_PORT0       12'h060
`define OFF_ECC_PORT1       12'h064
`define OFF_PHYS0_LO        12'h068
`define OFF_PHYS0_HI        12'h06C
`define OFF_PHYS1_LO        12'h070
`define OFF_PHYS1_HI        12'h074
`define OFF_MEM_LO          12'h078
`define OFF_MEM_HI          12'h07C
`define OFF_FIRST_ERR       12'h080
`define OFF_IRQ_ENABLE      12'h084

`define FES_W               8
`define FES_FATAL_PP        0
`define FES_DATA            1
`define FES_ECC0            2
`define FES_ECC1            3
`define FES_PHYS0           4
`define FES_PHYS1           5
`define FES_MEM             6
`define FES_UNLOGGED        7
`define FES_RESET           8'h00
`define IRQ_EN_RESET        8'h00

`define MEM_CHAN_BIT        39
`define MEM_DIMM_LSB        34
`define MEM_BANK_LSB        28
`define MEM_ROW_LSB         13
`define MEM_RSVD_W          24
`define COL_AP_BIT          10
`define LOG_DEFINED_CLKS    10

`endif

// ===== core/errlog_pkg.sv
// Types carried between the error detectors, the bus and the log bank.
package errlog_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        valid;
        logic [63:0] header;
    } hdr_event_s;

    typedef struct packed {
        logic         valid;
        logic         upper_half;
        logic [127:0] bus_data;
        logic [7:0]   data_parity_bits;
    } data_event_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] syndrome;
        logic [7:0] ecc;
    } ecc_event_s;

    typedef struct packed {
        logic        valid;
        logic        channel;
        logic [4:0]  dimm;
        logic [5:0]  bank;
        logic [14:0] row;
        logic [12:0] column;
    } mem_event_s;

endpackage

// ===== verif/error_detectors.sv
// Behavioural error detectors that raise one error event at a time.
`timescale 1ns/10ps
`default_nettype none
module error_detectors (
    input  wire logic [3:0]              kind,
    input  wire logic [127:0]            pay,
    input  wire logic                    upper,
    output errlog_pkg::hdr_event_s       fatal_pp_event,
    output errlog_pkg::data_event_s      data_event,
    output errlog_pkg::ecc_event_s       ecc_event_0,
    output errlog_pkg::ecc_event_s       ecc_event_1,
    output errlog_pkg::hdr_event_s       phys_event_0,
    output errlog_pkg::hdr_event_s       phys_event_1,
    output errlog_pkg::mem_event_s       mem_event,
    output var logic                     unlogged_event
);
    import errlog_pkg::*;
    // Between events the payload lines carry the inverse, so stale data is never mistaken.
    logic [127:0] w;
    assign w = (kind != 4'h0) ? pay : ~pay;
    assign fatal_pp_event = '{kind == 4'h1, w[63:0]};
    assign data_event = '{kind == 4'h2, upper, w, w[7:0] ^ 8'hA5};
    assign ecc_event_0 = '{kind == 4'h3, w[15:8], w[7:0]};
    assign ecc_event_1 = '{kind == 4'h4, w[15:8], w[7:0]};
    assign phys_event_0 = '{kind == 4'h5, w[63:0]};
    assign phys_event_1 = '{kind == 4'h6, w[63:0]};
    assign mem_event = '{kind == 4'h7, w[39], w[38:34], w[33:28], w[27:13], w[12:0]};
    assign unlogged_event = (kind == 4'h8);
endmodule
`default_nettype wire

// ===== verif/error_log_capture_registers_tb.sv
// Self-checking bench for the sticky error log bank.
`timescale 1ns/10ps
`default_nettype none
`include "errlog_params.svh"
module error_log_capture_registers_tb;
    import errlog_pkg::*;
    localparam logic [127:0] pat = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3B21;
    logic         sys_clk = 1'b0;
    logic         rst = 1'b1;
    logic         por = 1'b1;
    logic         upper = 1'b0;
    logic [3:0]   kind = 4'h0;
    logic [127:0] pay = '0;
    apb_req_s     apb_req = '0;
    logic         pready;
    logic         pslverr;
    logic         err_irq;
    logic [31:0]  prdata;
    hdr_event_s   fatal_pp_event;
    hdr_event_s   phys_event_0;
    hdr_event_s   phys_event_1;
    data_event_s  data_event;
    ecc_event_s   ecc_event_0;
    ecc_event_s   ecc_event_1;
    mem_event_s   mem_event;
    logic         unlogged_event;
    logic         err;
    logic [63:0]  got;
    logic [31:0]  r;
    int           bad_count = 0;
    int           checks = 0;
    logic [11:0]  addr_of [1:7] = '{`OFF_FATAL_PP_LO, `OFF_DATA_LO, `OFF_ECC_PORT0,
        `OFF_ECC_PORT1, `OFF_PHYS0_LO, `OFF_PHYS1_LO, `OFF_MEM_LO};

    always #20 sys_clk = ~sys_clk;

    error_log_capture_registers i_dut (.sys_clk, .rst, .por, .apb_req, .pready, .pslverr,
        .prdata, .fatal_pp_event, .data_event, .ecc_event_0, .ecc_event_1, .phys_event_0,
        .phys_event_1, .mem_event, .unlogged_event, .err_irq);
    error_detectors i_src (.kind, .pay, .upper, .fatal_pp_event, .data_event, .ecc_event_0,
        .ecc_event_1, .phys_event_0, .phys_event_1, .mem_event, .unlogged_event);

    // ====
    // Access tasks
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge sys_clk);
        apb_req <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb_req <= '0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        apb(1'b1, a, d, x);
    endtask

    task automatic rd64(input logic [11:0] a, output logic [63:0] v);
        logic [31:0] lo;
        logic [31:0] hi;
        apb(1'b0, a, 32'h0, lo);
        apb(1'b0, a + 12'h4, 32'h0, hi);
        v = {hi, lo};
    endtask

    task automatic fire(input logic [3:0] k, input logic [127:0] p, input logic u);
        @(posedge sys_clk);
        kind <= k;
        pay <= p;
        upper <= u;
        @(posedge sys_clk);
        kind <= 4'h0;
        repeat (`LOG_DEFINED_CLKS) @(posedge sys_clk);
    endtask

    function automatic logic [63:0] exp_log(input int k, input logic [127:0] p);
        case (k)
            2: return p[127:64];
            3, 4: return {48'h0, p[15:0]};
            7: return {24'h0, p[39:0] | 40'h400};
            default: return p[63:0];
        endcase
    endfunction

    // Logs of kinds up to n hold the first loaded pattern, the rest are zero.
    task automatic scan(input int n);
        for (int k = 1; k <= 7; k++)
        begin
            rd64(addr_of[k], got);
            if (k == 3 || k == 4)
                got[63:32] = 32'h0;
            chk(got, (k <= n) ? exp_log(k, pat ^ (128'(k) << 4)) : 64'h0);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ====
    // Tests
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        por <= 1'b0;
        scan(0);
        wr(`OFF_FATAL_PP_LO, 32'hFFFF_FFFF);
        rd64(`OFF_FATAL_PP_LO, got);
        chk(got, 64'h0);
        apb(1'b0, 12'h0F0, 32'h0, r);
        chk({r, 31'h0, err}, 64'h1);
        $display("test power_up done");
        fire(4'h8, pat, 1'b0);
        apb(1'b0, `OFF_FIRST_ERR, 32'h0, r);
        chk(r, 64'h80);
        scan(0);
        wr(`OFF_FIRST_ERR, 32'h80);
        $display("test unlogged done");
        for (int k = 1; k <= 7; k++)
            fire(4'(k), pat ^ (128'(k) << 4), 1'b1);
        scan(7);
        apb(1'b0, `OFF_DATA_PAR, 32'h0, r);
        chk(r, {56'h0, pat[7:0] ^ 8'h20 ^ 8'hA5});
        apb(1'b0, `OFF_FIRST_ERR, 32'h0, r);
        chk(r, 64'h7F);
        $display("test capture done");
        for (int k = 1; k <= 7; k++)
            fire(4'(k), ~pat, 1'b0);
        scan(7);
        wr(`OFF_FIRST_ERR, 32'h3);
        fire(4'h2, pat, 1'b0);
        fire(4'h1, ~pat, 1'b0);
        rd64(`OFF_DATA_LO, got);
        chk(got, pat[63:0]);
        rd64(`OFF_FATAL_PP_LO, got);
        chk(got, ~pat[63:0]);
        $display("test hold_and_reload done");
        wr(`OFF_IRQ_ENABLE, 32'h1);
        @(posedge sys_clk);
        chk(err_irq, 64'h1);
        wr(`OFF_IRQ_ENABLE, 32'h0);
        @(posedge sys_clk);
        chk(err_irq, 64'h0);
        wr(`OFF_IRQ_ENABLE, 32'h1);
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk(err_irq, 64'h0);
        apb(1'b0, `OFF_IRQ_ENABLE, 32'h0, r);
        chk(r, 64'h0);
        rd64(`OFF_FATAL_PP_LO, got);
        chk(got, ~pat[63:0]);
        wr(`OFF_IRQ_ENABLE, 32'h40);
        @(posedge sys_clk);
        chk(err_irq, 64'h1);
        wr(`OFF_FIRST_ERR, 32'hFF);
        @(posedge sys_clk);
        chk(err_irq, 64'h0);
        $display("test interrupt_and_warm_reset done");
        give_verdict();
    end

    // The whole sequence needs about five hundred cycles; this cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
